//--- design/msb_buffer.sv
// Purpose: Multi-event sample buffer datapath and pointers, one block.
// Assumes: Link clock sampled by sys_clk; accepted triggers arrive
//          as buffer_done pulses from the trigger logic.
// Notes: Memory slots alternate write (slot 0) and read (slot 1).
// Function
// - Resynchronise link to sys_clk, then capture samples on link clock rise
// - Mix filtered and raw samples into 16-bit word
// - Alternate memory between write and read accesses
// - Strobe even and odd halves into word
// - 8K sample locations per channel, equal buffers
// - 3-bit size mode picks buffer layout
// - Write continuously, circular within write buffer
// - Reads use read buffer, independent of writes
// - Accepted trigger completion advances write pointer
// - Read pointer advances only on host write
// - Read sequentially, wrap within same buffer
// - Host reads full 32-bit words
// - Each word holds two adjacent channels
// - One sampling instant fills eight words
// - Report stop location of last sample
// - Read and write pointers visible to host
// - Status full, empty or not empty
// - Mark channel 15 in, channel 0 out
// - Sample peak flags only during strobe
// - Four unit selects, four-bit parameter parts
// - Strobe rising edge latches; read select direction
module msb_buffer #(
    parameter int PHASE_CYC = msb_pkg::PARAM_PHASE_CYC
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // Link from the converters
    input wire logic link_clk,
    input wire msb_pkg::msb_link_t link_word,
    // Buffer control
    input wire logic [msb_pkg::MODE_W-1:0] size_mode,
    input wire logic buffer_done,
    input wire logic read_buffer_advance,
    input wire logic buffer_clear,
    input wire logic filter_reset_req,
    // Host readout
    input wire logic rd_req,
    output logic rd_ready,
    output logic rd_valid,
    output logic [31:0] rd_data,
    // Status
    output msb_pkg::msb_status_t status,
    // Peak-finder stream
    output logic filter_clock,
    output logic [msb_pkg::SMP_W-1:0] raw_sample_in,
    output logic input_channel_marker_n,
    input wire logic [msb_pkg::SMP_W-1:0] filtered_sample_out,
    input wire logic outbound_sync_marker,
    input wire logic peak_sample_strobe_n,
    input wire logic [msb_pkg::CH_N-1:0] peak_flags,
    input wire logic filter_overflow_flag,
    output logic filter_control_reset_n,
    // Peak-finder parameter port
    input wire msb_pkg::msb_param_cmd_t param_cmd,
    output logic param_busy,
    output logic [msb_pkg::NIB_W-1:0] param_rdata,
    output logic [msb_pkg::UNIT_N-1:0] unit_select_n,
    output logic [3:0] param_addr,
    output logic param_read_select,
    output logic param_strobe,
    input wire logic [15:0] param_bus_i,
    output logic [15:0] param_bus_o,
    output logic param_bus_oe
);
    import msb_pkg::*;

    initial begin
        if (PHASE_CYC < 1 || PHASE_CYC > 255) begin
            $error("msb_buffer: PHASE_CYC out of range");
        end
    end

    // Two-stage synchronisers for everything arriving from pins
    localparam int SY_W = 1 + 21 + SMP_W + 3 + CH_N + 16;
    logic [SY_W-1:0] sy_in, sy1, sy2;
    logic clk_d;
    assign sy_in = {link_clk, link_word, filtered_sample_out,
        outbound_sync_marker, peak_sample_strobe_n,
        filter_overflow_flag, peak_flags, param_bus_i};
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sy1 <= '0;
            sy2 <= '0;
            clk_d <= 1'b0;
        end else if (ce) begin
            sy1 <= sy_in;
            sy2 <= sy1;
            clk_d <= sy2[SY_W-1];
        end
    end
    msb_link_t lnk;
    logic [SMP_W-1:0] filt_s;
    logic osync_s, pstb_n_s, ovfl_s, rise;
    logic [CH_N-1:0] peaks_s;
    logic [15:0] pbus_s;
    assign {lnk, filt_s, osync_s, pstb_n_s, ovfl_s, peaks_s, pbus_s} =
        sy2[SY_W-2:0];
    assign rise = sy2[SY_W-1] & ~clk_d; // Link clock rising edge

    // Stream state: channel counters, raw store, peak flags
    logic [CH_W-1:0] in_ch, next_in_ch, out_ch, next_out_ch;
    logic [SMP_W-1:0] raw_q, next_raw_q, filt_q, next_filt_q;
    logic [SMP_W-1:0] raw_hold [CH_N];
    logic [SMP_W-1:0] next_raw_hold [CH_N];
    logic [CH_N-1:0] peak_hold, next_peak_hold;
    logic smp_go;
    always_comb begin
        next_in_ch = in_ch;
        next_out_ch = out_ch;
        next_raw_q = raw_q;
        next_filt_q = filt_q;
        next_raw_hold = raw_hold;
        next_peak_hold = peak_hold;
        if (rise) begin
            next_raw_q = lnk.blk_a;
            next_in_ch = lnk.sync ? CH_FIRST : 4'(in_ch + 4'h1);
            next_raw_hold[next_in_ch] = lnk.blk_a;
            next_filt_q = filt_s;
            next_out_ch = osync_s ? CH_FIRST : 4'(out_ch + 4'h1);
        end
        if (!pstb_n_s) begin
            next_peak_hold = peaks_s;
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            in_ch <= CH_LAST;
            out_ch <= CH_LAST;
            raw_q <= '0;
            filt_q <= '0;
            raw_hold <= '{default: '0};
            peak_hold <= '0;
            smp_go <= 1'b0;
        end else if (ce) begin
            in_ch <= next_in_ch;
            out_ch <= next_out_ch;
            raw_q <= next_raw_q;
            filt_q <= next_filt_q;
            raw_hold <= next_raw_hold;
            peak_hold <= next_peak_hold;
            smp_go <= rise;
        end
    end
    // Marker and chip clock come from flops, so they never glitch
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            input_channel_marker_n <= 1'b1;
            filter_clock <= 1'b0;
            filter_control_reset_n <= 1'b0;
        end else if (ce) begin
            input_channel_marker_n <= (next_in_ch != CH_LAST);
            filter_clock <= clk_d;
            filter_control_reset_n <= ~filter_reset_req;
        end
    end
    assign raw_sample_in = raw_q;

    // Mixed word: filtered MSBs, peak flag, raw sample
    logic [WORD_W-1:0] mix;
    assign mix = {filt_q[SMP_W-1:FILT_KEEP_LSB], peak_hold[out_ch],
        raw_hold[out_ch]};

    // Pointer state
    logic [PTR_W-1:0] wptr, next_wptr, rptr, next_rptr;
    logic full, next_full, empty, next_empty;
    logic [LOC_W-1:0] stop_loc, next_stop_loc, last_off;
    logic wadv, radv;
    assign wadv = buffer_done & ~full;
    assign radv = read_buffer_advance & ~empty;
    always_comb begin
        next_wptr = wptr;
        next_rptr = rptr;
        next_full = full;
        next_empty = empty;
        next_stop_loc = stop_loc;
        if (buffer_clear) begin
            next_wptr = PTR_RST;
            next_rptr = PTR_RST;
            next_full = 1'b0;
            next_empty = 1'b1;
        end else begin
            if (wadv) begin
                next_wptr = 7'(wptr + 7'h01) & msb_ptr_mask(size_mode);
                next_stop_loc = last_off;
            end
            if (radv) begin
                next_rptr = 7'(rptr + 7'h01) & msb_ptr_mask(size_mode);
            end
            if (next_wptr != next_rptr) begin
                next_full = 1'b0;
                next_empty = 1'b0;
            end else if (wadv && !radv) begin
                next_full = 1'b1;
                next_empty = 1'b0;
            end else if (radv && !wadv) begin
                next_full = 1'b0;
                next_empty = 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wptr <= PTR_RST;
            rptr <= PTR_RST;
            full <= 1'b0;
            empty <= 1'b1;
            stop_loc <= LOC_RST;
        end else if (ce) begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            full <= next_full;
            empty <= next_empty;
            stop_loc <= next_stop_loc;
        end
    end
    assign status = '{full: full, empty: empty,
        not_empty: ~full & ~empty, overflow: ovfl_s,
        wr_ptr: wptr, rd_ptr: rptr, stop_loc: stop_loc};

    // Write path: one pending word, served in the next write slot
    logic slot;
    logic [LOC_W-1:0] wr_off, next_wr_off, next_last_off;
    logic wr_pend, next_wr_pend;
    logic [MEM_AW-1:0] wr_addr, next_wr_addr;
    logic [WORD_W-1:0] wr_data, next_wr_data;
    logic mem_we;
    always_comb begin
        next_wr_off = wr_off;
        next_last_off = last_off;
        next_wr_pend = wr_pend & ~mem_we;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        // Set after clear: a new sample is never dropped
        if (smp_go) begin
            next_wr_pend = 1'b1;
            next_wr_addr = {msb_loc(size_mode, wptr, wr_off), out_ch};
            next_wr_data = mix;
            if (out_ch == CH_LAST) begin
                next_last_off = wr_off;
                next_wr_off = 13'(wr_off + 13'h0001)
                    & msb_off_mask(size_mode);
            end
        end
        if (buffer_clear || wadv) begin
            next_wr_off = LOC_RST;
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            slot <= 1'b0;
            wr_off <= LOC_RST;
            last_off <= LOC_RST;
            wr_pend <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
        end else if (ce) begin
            slot <= ~slot;
            wr_off <= next_wr_off;
            last_off <= next_last_off;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
        end
    end

    // Read path: even half, then odd half, into one host word
    typedef enum logic [2:0] {
        RD_IDLE, RD_EVEN, RD_GET_EVEN, RD_ODD, RD_GET_ODD
    } msb_rd_state_t;
    msb_rd_state_t rd_st, next_rd_st;
    logic [IDX_W-1:0] rd_idx, next_rd_idx, rd_last;
    logic [WORD_W-1:0] lo, next_lo, mem_rdata;
    logic [31:0] next_rd_data;
    logic [MEM_AW-1:0] rd_addr, mem_addr;
    assign rd_last = {msb_off_mask(size_mode), PAIR_LAST};
    assign rd_addr = {msb_loc(size_mode, rptr, rd_idx[IDX_W-1:3]),
        rd_idx[2:0], rd_st == RD_ODD};
    assign rd_ready = (rd_st == RD_IDLE);
    assign rd_valid = (rd_st == RD_GET_ODD) & ce;
    assign mem_we = ~slot & wr_pend;
    assign mem_addr = mem_we ? wr_addr : rd_addr;
    always_comb begin
        next_rd_st = rd_st;
        next_rd_idx = rd_idx;
        next_lo = lo;
        next_rd_data = rd_data;
        case (rd_st)
            RD_IDLE: begin
                if (rd_req) begin
                    next_rd_st = RD_EVEN;
                end
            end
            RD_EVEN: begin
                if (slot) begin
                    next_rd_st = RD_GET_EVEN;
                end
            end
            RD_GET_EVEN: begin
                next_lo = mem_rdata;
                next_rd_st = RD_ODD;
            end
            RD_ODD: begin
                next_rd_st = RD_GET_ODD;
            end
            RD_GET_ODD: begin
                next_rd_data = {mem_rdata, lo};
                next_rd_idx = (rd_idx == rd_last) ? '0
                    : IDX_W'(rd_idx + 1'b1);
                next_rd_st = RD_IDLE;
            end
            default: begin
                next_rd_st = RD_IDLE;
            end
        endcase
        if (radv || buffer_clear) begin
            next_rd_idx = '0;
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_st <= RD_IDLE;
            rd_idx <= '0;
            lo <= '0;
            rd_data <= '0;
        end else if (ce) begin
            rd_st <= next_rd_st;
            rd_idx <= next_rd_idx;
            lo <= next_lo;
            rd_data <= next_rd_data;
        end
    end

    msb_mem #(.DW(WORD_W), .AW(MEM_AW)) u_mem (
        .clk(sys_clk),
        .ce(ce),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(wr_data),
        .rdata(mem_rdata)
    );

    // Parameter port: select, strobe high, hold, per 4-channel unit
    typedef enum logic [1:0] {PS_IDLE, PS_SETUP, PS_STROBE, PS_HOLD}
        msb_ps_state_t;
    msb_ps_state_t ps, next_ps;
    logic [7:0] pcnt, next_pcnt;
    msb_param_cmd_t pc, next_pc;
    logic [NIB_W-1:0] next_param_rdata;
    logic pdone;
    assign pdone = (pcnt == 8'(PHASE_CYC - 1));
    always_comb begin
        next_ps = ps;
        next_pc = pc;
        next_pcnt = pdone ? 8'h00 : 8'(pcnt + 8'h01);
        next_param_rdata = param_rdata;
        case (ps)
            PS_IDLE: begin
                next_pcnt = 8'h00;
                if (param_cmd.go) begin
                    next_pc = param_cmd;
                    next_ps = PS_SETUP;
                end
            end
            PS_SETUP: begin
                if (pdone) next_ps = PS_STROBE;
            end
            PS_STROBE: begin
                if (pdone) next_ps = PS_HOLD;
            end
            PS_HOLD: begin
                if (pdone) begin
                    next_param_rdata = pbus_s[pc.unit*NIB_W +: NIB_W];
                    next_ps = PS_IDLE;
                end
            end
            default: begin
                next_ps = PS_IDLE;
            end
        endcase
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ps <= PS_IDLE;
            pcnt <= 8'h00;
            pc <= '0;
            param_rdata <= '0;
        end else if (ce) begin
            ps <= next_ps;
            pcnt <= next_pcnt;
            pc <= next_pc;
            param_rdata <= next_param_rdata;
        end
    end
    // Pins are flops; the bus drives only on writes, chip drives reads
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            unit_select_n <= SEL_IDLE_N;
            param_addr <= 4'h0;
            param_read_select <= 1'b0;
            param_strobe <= 1'b0;
            param_bus_o <= 16'h0000;
            param_bus_oe <= 1'b0;
        end else if (ce) begin
            unit_select_n <= (next_ps == PS_IDLE) ? SEL_IDLE_N
                : ~(4'h1 << next_pc.unit);
            param_addr <= next_pc.addr;
            param_read_select <= next_pc.rd;
            param_strobe <= (next_ps == PS_STROBE);
            param_bus_o <= next_pc.wdata;
            param_bus_oe <= (next_ps != PS_IDLE) & ~next_pc.rd;
        end
    end
    assign param_busy = (ps != PS_IDLE);

    // Checks; helper counts enabled cycles of one read
    logic [3:0] rd_busy_cnt;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_busy_cnt <= 4'h0;
        end else if (ce) begin
            rd_busy_cnt <= (next_rd_st == RD_IDLE) ? 4'h0
                : 4'(rd_busy_cnt + 4'h1);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_full_on_wadv: assert property (ce && !buffer_clear && wadv && !radv
        && next_wptr == rptr |=> full && !empty)
        else $error("full not set by write advance");
    a_empty_on_clr: assert property (ce && buffer_clear |=> empty && !full
        && wptr == PTR_RST && rptr == PTR_RST)
        else $error("clear did not empty buffer");
    a_rptr_only_adv: assert property (ce && !read_buffer_advance
        && !buffer_clear |=> $stable(rptr))
        else $error("read pointer moved by itself");
    a_wptr_step: assert property (ce && buffer_done && !full
        && !buffer_clear |=> wptr == (7'($past(wptr) + 7'h01)
        & msb_ptr_mask(size_mode)))
        else $error("write pointer did not step");
    a_marker_ch15: assert property ($fell(input_channel_marker_n)
        |-> in_ch == CH_LAST)
        else $error("input marker not on channel 15");
    a_peak_gated: assert property (ce && pstb_n_s
        |=> $stable(peak_hold))
        else $error("peak flags sampled without strobe");
    a_read_bound: assert property (rd_busy_cnt <= 4'h5)
        else $error("read took too long");
    a_read_wrap: assert property (rd_valid && rd_idx == rd_last
        && !read_buffer_advance && !buffer_clear |=> rd_idx == '0)
        else $error("readout did not wrap");
    a_strobe_sel: assert property ($rose(param_strobe) |->
        unit_select_n != SEL_IDLE_N
        && param_bus_oe == !param_read_select)
        else $error("strobe without select or direction");
    a_write_slot: assert property (mem_we |-> !slot && $past(slot)
        || !ce || !$past(ce))
        else $error("write outside write slot");
endmodule : msb_buffer

//--- design/msb_pkg.sv
// Purpose: Shared constants, types and helpers of the sample buffer.
// Assumes: One 16-channel block, 100 MHz system clock.
// Notes: Memory location = buffer pointer above sample offset.
package msb_pkg;
    // Clock and timing
    localparam int SYS_CLK_MHZ = 100;
    localparam int PARAM_PHASE_NS = 50;
    // Least time, rounded up to whole cycles
    localparam int PARAM_PHASE_CYC =
        (PARAM_PHASE_NS * SYS_CLK_MHZ + 999) / 1000;
    // Widths
    localparam int SMP_W = 10;
    localparam int WORD_W = 16;
    localparam int CH_N = 16;
    localparam int CH_W = 4;
    localparam int LOC_W = 13;
    localparam int PTR_W = 7;
    localparam int MODE_W = 3;
    localparam int MEM_AW = LOC_W + CH_W;
    localparam int IDX_W = LOC_W + 3;
    localparam int UNIT_N = 4;
    localparam int NIB_W = 4;
    // Size modes
    localparam logic [2:0] MODE_TEST = 3'h7;
    localparam logic [3:0] BASE_SHIFT = 4'h6;
    localparam logic [3:0] TEST_SHIFT = 4'h3;
    localparam logic [6:0] PTR_MASK_FULL = 7'h7f;
    localparam logic [6:0] PTR_MASK_TEST = 7'h01;
    // Channel markers
    localparam logic [3:0] CH_FIRST = 4'h0;
    localparam logic [3:0] CH_LAST = 4'hf;
    localparam logic [2:0] PAIR_LAST = 3'h7;
    // Mixed word layout
    localparam int MIX_PEAK_BIT = 10;
    localparam int MIX_FILT_LSB = 11;
    localparam int FILT_KEEP_LSB = 5;
    // Reset values
    localparam logic [6:0] PTR_RST = 7'h00;
    localparam logic [12:0] LOC_RST = 13'h0000;
    localparam logic [3:0] SEL_IDLE_N = 4'hf;

    typedef struct packed {
        logic sync;
        logic [SMP_W-1:0] blk_b;
        logic [SMP_W-1:0] blk_a;
    } msb_link_t;

    typedef struct packed {
        logic go;
        logic rd;
        logic [1:0] unit;
        logic [3:0] addr;
        logic [15:0] wdata;
    } msb_param_cmd_t;

    typedef struct packed {
        logic full;
        logic empty;
        logic not_empty;
        logic overflow;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [LOC_W-1:0] stop_loc;
    } msb_status_t;

    // Log2 of samples per buffer for a size mode
    function automatic logic [3:0] msb_shift(input logic [2:0] mode);
        return (mode == MODE_TEST) ? TEST_SHIFT : BASE_SHIFT + 4'(mode);
    endfunction : msb_shift

    function automatic logic [12:0] msb_off_mask(input logic [2:0] mode);
        return 13'((14'h0001 << msb_shift(mode)) - 14'h0001);
    endfunction : msb_off_mask

    function automatic logic [6:0] msb_ptr_mask(input logic [2:0] mode);
        return (mode == MODE_TEST) ? PTR_MASK_TEST : PTR_MASK_FULL >> mode;
    endfunction : msb_ptr_mask

    function automatic logic [12:0] msb_loc(input logic [2:0] mode,
            input logic [6:0] ptr, input logic [12:0] off);
        logic [12:0] p;
        p = 13'(ptr & msb_ptr_mask(mode));
        return (p << msb_shift(mode)) | (off & msb_off_mask(mode));
    endfunction : msb_loc
endpackage : msb_pkg

//--- design/msb_mem.sv
// Purpose: Single-port sample memory with registered read data.
// Assumes: One access per cycle; caller arbitrates write and read.
// Notes: Read data appear one cycle after the address.
module msb_mem #(
    parameter int DW = 16,
    parameter int AW = 17
) (
    // Clock
    input wire logic clk,
    input wire logic ce,
    // Access
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    initial begin
        if (DW < 1 || AW < 1 || AW > 24) begin
            $error("msb_mem: unsupported size");
        end
    end

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // No reset on the array: contents are undefined until written
    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule : msb_mem

//--- tb/msb_far_end.sv
// Purpose: Far side model: converter link and peak-finder chip.
// Assumes: Link clock runs free at 6.25 MHz; chip latency one sample.
// Notes: Each channel carries a fixed code, so latency never skews data.
module msb_far_end (
    // Link
    output logic link_clk,
    output msb_pkg::msb_link_t link_word,
    // Chip stream
    input wire logic filter_clock,
    input wire logic [9:0] raw_sample_in,
    input wire logic input_channel_marker_n,
    output logic [9:0] filtered_sample_out,
    output logic outbound_sync_marker,
    // Chip parameter port
    input wire logic param_read_select,
    input wire logic [3:0] unit_select_n,
    input wire logic param_bus_oe,
    input wire logic [15:0] param_bus_o,
    output logic [15:0] param_bus_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import msb_pkg::*;
    logic [3:0] ch = 4'h0;
    logic mark_seen = 1'b0;

    // Free link; word changes on the falling edge, well inside the period
    initial begin
        link_clk = 1'b0;
        link_word = '0;
        filtered_sample_out = '0;
        outbound_sync_marker = 1'b0;
        #3;
        forever begin
            #80 link_clk = ~link_clk;
            if (!link_clk) begin
                link_word = {ch == 4'h0, ~{ch, 6'h2a}, ch, 6'h2a};
                ch = ch + 4'h1;
            end
        end
    end

    // One-sample delay; output sync follows the channel 15 input mark
    always @(posedge filter_clock) begin
        filtered_sample_out <= raw_sample_in;
        outbound_sync_marker <= mark_seen;
        mark_seen <= !input_channel_marker_n;
    end

    // Chip drives only when read-selected; a released bus shows a decoy
    assign param_bus_i = (param_read_select && unit_select_n != 4'hf) ?
        16'hc3a5 : (param_bus_oe ? param_bus_o : 16'h3c5a);
endmodule : msb_far_end

//--- tb/tb.sv
// Purpose: Self-checking bench of the sample buffer.
// Assumes: Test size mode, two buffers of eight samples.
// Notes: Reads overlap live writes; expectations come from channel codes.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import msb_pkg::*;
    logic sys_clk = 1'b0, arst_n = 1'b0, buffer_done = 1'b0;
    logic read_buffer_advance = 1'b0, buffer_clear = 1'b0, rd_req = 1'b0;
    logic filter_overflow_flag = 1'b0, rd_ready, rd_valid, filter_clock;
    logic input_channel_marker_n, filter_control_reset_n, param_busy;
    logic param_read_select, param_strobe, param_bus_oe;
    logic link_clk, outbound_sync_marker;
    logic [2:0] size_mode = MODE_TEST;
    logic [2:0] flags;
    logic [3:0] param_rdata, unit_select_n, param_addr;
    logic [9:0] raw_sample_in, filtered_sample_out;
    logic [15:0] param_bus_i, param_bus_o;
    logic [31:0] rd_data, w;
    msb_link_t link_word;
    msb_status_t status;
    msb_param_cmd_t param_cmd = '0;
    int err_total = 0, cmp_count = 0, n;

    assign flags = {status.full, status.empty, status.not_empty};

    // Short parameter phases keep each chip access brief
    msb_buffer #(.PHASE_CYC(2)) dut (
        .sys_clk, .arst_n, .ce(1'b1), .link_clk, .link_word, .size_mode,
        .buffer_done, .read_buffer_advance, .buffer_clear,
        .filter_reset_req(1'b0), .rd_req, .rd_ready, .rd_valid, .rd_data,
        .status, .filter_clock, .raw_sample_in, .input_channel_marker_n,
        .filtered_sample_out, .outbound_sync_marker,
        .peak_sample_strobe_n(1'b1), .peak_flags(16'h0000),
        .filter_overflow_flag, .filter_control_reset_n, .param_cmd,
        .param_busy, .param_rdata, .unit_select_n, .param_addr,
        .param_read_select, .param_strobe, .param_bus_i, .param_bus_o,
        .param_bus_oe);
    msb_far_end far (.link_clk, .link_word, .filter_clock, .raw_sample_in,
        .input_channel_marker_n, .filtered_sample_out, .outbound_sync_marker,
        .param_read_select, .unit_select_n, .param_bus_oe, .param_bus_o,
        .param_bus_i);

    // System clock, 100 MHz
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Step past the edge so its updates have landed
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic op(input logic d, a);
        @(posedge sys_clk);
        buffer_done <= d;
        read_buffer_advance <= a;
        @(posedge sys_clk);
        buffer_done <= 1'b0;
        read_buffer_advance <= 1'b0;
        tick(1);
    endtask : op

    task automatic rd_word(output logic [31:0] d);
        @(posedge sys_clk);
        rd_req <= 1'b1;
        @(posedge sys_clk);
        rd_req <= 1'b0;
        n = 0;
        #1;
        while (rd_valid !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        tick(1);
        d = rd_data;
        chk("read wait", 32'(n < 20), 32'h1);
    endtask : rd_word

    task automatic par(input logic rd, input logic [1:0] u);
        @(posedge sys_clk);
        param_cmd <= '{1'b1, rd, u, 4'h3, 16'h5a3c};
        @(posedge sys_clk);
        param_cmd.go <= 1'b0;
        n = 0;
        #1;
        while (param_strobe !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        chk("unit sel", unit_select_n, 32'(4'(~(4'h1 << u))));
        chk("rd sel", param_read_select, 32'(rd));
        chk("bus oe", param_bus_oe, 32'(!rd));
        chk("addr", param_addr, 32'h3);
        chk("bus data", param_bus_o, 32'h5a3c);
        while (param_busy !== 1'b0 && n < 50) begin
            tick(1);
            n++;
        end
        tick(1);
        if (rd) chk("nibble", param_rdata, 32'(4'(16'hc3a5 >> 4 * u)));
    endtask : par

    function automatic logic [15:0] half(input logic [3:0] c);
        return {c, 1'b1, 1'b0, c, 6'h2a};
    endfunction : half

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // Tests take about 40 us; a hang is cut at five times that
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        tick(1);
        chk("reset flags", flags, 32'h2);
        chk("ctl reset", filter_control_reset_n, 32'h1);
        op(1'b0, 1'b0);
        buffer_clear <= 1'b1;
        filter_overflow_flag <= 1'b1;
        op(1'b0, 1'b0);
        buffer_clear <= 1'b0;
        n = 0;
        while (input_channel_marker_n !== 1'b0 && n < 400) begin
            tick(1);
            n++;
        end
        chk("ch15 mark", raw_sample_in, {4'hf, 6'h2a});
        chk("overflow", status.overflow, 32'h1);
        $display("stream test done");
        // Reads run while the same buffer keeps being written
        tick(3000);
        for (int k = 0; k < 66; k++) begin
            rd_word(w);
            chk("word", w, {half(4'(2*k+1)), half(4'(2*k))});
        end
        $display("readout test done");
        op(1'b1, 1'b0);
        chk("wr ptr", status.wr_ptr, 32'h1);
        chk("flags", flags, 32'h1);
        op(1'b0, 1'b1);
        chk("rd ptr", status.rd_ptr, 32'h1);
        chk("flags", flags, 32'h2);
        op(1'b0, 1'b1);
        chk("rd ptr held", status.rd_ptr, 32'h1);
        op(1'b1, 1'b0);
        op(1'b1, 1'b0);
        chk("full", flags, 32'h4);
        op(1'b1, 1'b0);
        chk("full held", flags, 32'h4);
        $display("pointer test done");
        size_mode <= 3'h0;
        buffer_clear <= 1'b1;
        op(1'b0, 1'b0);
        buffer_clear <= 1'b0;
        op(1'b1, 1'b0);
        op(1'b1, 1'b0);
        chk("mode 0 ptr", status.wr_ptr, 32'h2);
        for (int u = 0; u < 4; u++) par(1'b0, 2'(u));
        par(1'b1, 2'h1);
        $display("parameter test done");
        report_and_stop();
    end
endmodule : tb
